/* rtl/cue_cap_if.sv */
// ============================================================
// Purpose: link between register front end and capture core
// Assumes: both ends on sys_clk
// Notes:   evt is a one-cycle pulse per capture event
`timescale 1ns/1ps
interface cue_cap_if;
	import cue_pkg::*;

	logic              capIn;
	logic              syncPulse;
	logic              run;
	logic              falling;
	logic              filtReset;
	logic [3:0]        clrFlags;
	cue_word_t         counter;
	cue_word_t         capVal [4];
	logic [1:0]        seq;
	logic [3:0]        flags;
	logic [3:0]        evt;

	modport front (output capIn, syncPulse, run, falling, filtReset,
		clrFlags, input counter, capVal, seq, flags, evt);
	modport core (input capIn, syncPulse, run, falling, filtReset,
		clrFlags, output counter, capVal, seq, flags, evt);
endinterface : cue_cap_if

/* rtl/cue_capture_core.sv */
// ============================================================
// Purpose: time base, edge detect, four-slot event sequencer
// Assumes: capIn already synchronised to sys_clk
// Notes:   flag set wins over a clear in the same cycle
`timescale 1ns/1ps
module cue_capture_core
	import cue_pkg::*;
(
	input  wire logic  sys_clk,
	input  wire logic  arst_n,
	cue_cap_if.core    cap
);

	cue_word_t  counterQ, counterD;
	cue_word_t  capQ [4];
	cue_word_t  capD [4];
	logic [1:0] seqQ, seqD;
	logic [3:0] flagsQ, flagsD;
	logic [3:0] evtQ, evtD;
	logic       prevQ, prevD;
	logic       edgeHit;

	// ============================================================
	// next state of time base and sequencer
	always_comb begin
		counterD = counterQ;
		capD     = capQ;
		seqD     = seqQ;
		evtD     = 4'h0;
		prevD    = cap.capIn;
		edgeHit  = cap.falling ? (prevQ && !cap.capIn)
			: (!prevQ && cap.capIn);
		flagsD   = flagsQ & ~cap.clrFlags;
		if (cap.syncPulse) begin
			counterD = 32'h0000_0000;
		end else if (cap.run) begin
			counterD = counterQ + 32'h0000_0001;
		end
		if (cap.filtReset) begin
			seqD  = 2'h0;
			prevD = cap.capIn;
		end else if (edgeHit && cap.run) begin
			capD[seqD]   = counterQ;
			flagsD[seqQ] = 1'b1;                // set wins
			evtD[seqQ]   = 1'b1;
			seqD         = seqQ + 2'h1;
		end
	end

	// ============================================================
	// registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			counterQ <= 32'h0000_0000;
			for (int i = 0; i < 4; i++) begin
				capQ[i] <= 32'h0000_0000;
			end
			seqQ   <= 2'h0;
			flagsQ <= 4'h0;
			evtQ   <= 4'h0;
			prevQ  <= 1'b0;
		end else begin
			counterQ <= counterD;
			capQ     <= capD;
			seqQ     <= seqD;
			flagsQ   <= flagsD;
			evtQ     <= evtD;
			prevQ    <= prevD;
		end
	end

	assign cap.counter = counterQ;
	assign cap.capVal  = capQ;
	assign cap.seq     = seqQ;
	assign cap.flags   = flagsQ;
	assign cap.evt     = evtQ;

endmodule : cue_capture_core

/* rtl/cue_capture_unit.sv */
// ============================================================
// Purpose: capture unit with AXI4-Lite registers
// Assumes: capture sources are asynchronous pins, sync sources and
//          high-res fine bits come from logic on sys_clk
// Notes:   one write and one read in flight at most
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "cue_params.svh"

// Notes on behaviour
// - the counter sync input is any peer pwm or capture sync output, picked by a select field, in any order.
// - there are seven capture units, and only the sixth and seventh keep high-resolution fine bits.
// - writing one to the event filter reset bit returns the event filter to its start state.
// - status bits show the live value of the modulo event sequencer.
// - the capture input select resets to 127, the legacy fixed crossbar input.
// - write protection is off after reset and on once software sets the protect bit.
module cue_capture_unit
	import cue_pkg::*;
#(
	parameter int UNIT_INDEX = 1,
	parameter int NUM_SRC    = 128,
	parameter int NUM_SYNC   = 39,
	parameter int FINE_W     = 8
)(
	input  wire logic                sys_clk,
	input  wire logic                arst_n,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic [NUM_SRC-1:0]  captureSources,
	input  wire logic [NUM_SYNC-1:0] syncSources,
	input  wire logic [FINE_W-1:0]   hiResFine,
	input  wire logic                protectedWriteGate,
	output logic                     syncOutput,
	output logic                     dmaRequest
);

	localparam bit HIGH_RES = (UNIT_INDEX >= 6) && (UNIT_INDEX <= 7);

	cue_cap_if cap ();

	// ============================================================
	// state
	logic [NUM_SRC-1:0] srcMetaQ, srcSyncQ;
	logic       runQ, runD, fallQ, fallD, dmaEnQ, dmaEnD;
	cue_evt_t   dmaSelQ, dmaSelD;
	logic [6:0] inSelQ, inSelD;
	logic [5:0] syncSelQ, syncSelD;
	logic       syncEnQ, syncEnD, protQ, protD;
	logic       filtRstQ, filtRstD;
	logic [3:0] clrQ, clrD;
	logic [FINE_W-1:0] fineQ, fineD;
	logic       dmaReqQ, dmaReqD, syncOutQ, syncOutD;
	logic       awRdyQ, awRdyD, wRdyQ, wRdyD, bValQ, bValD;
	logic [1:0] bRespQ, bRespD, rRespQ, rRespD;
	logic       arRdyQ, arRdyD, rValQ, rValD;
	logic [7:0] awAddrQ, awAddrD;
	cue_word_t  wDataQ, wDataD, rDataQ, rDataD, wVal;
	logic [3:0] wStrbQ, wStrbD;
	logic       syncHit, doWrite;

	// byte-lane merge of a write into the current register view
	function automatic cue_word_t laneMerge(input cue_word_t oldV,
		input cue_word_t newV, input logic [3:0] strb);
		cue_word_t r;
		r = oldV;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = newV[b*8 +: 8];
			end
		end
		return r;
	endfunction : laneMerge

	// view of a register as software reads it
	function automatic cue_word_t regView(input logic [7:0] a);
		cue_word_t v;
		v = 32'h0000_0000;
		case (a)
			`CUE_OFF_CTRL: begin
				v[`CUE_CTRL_RUN]         = runQ;
				v[`CUE_CTRL_DMASEL +: 2] = dmaSelQ;
				v[`CUE_CTRL_DMAEN]       = dmaEnQ;
				v[`CUE_CTRL_FALLING]     = fallQ;
			end
			`CUE_OFF_INSEL:   v[6:0] = inSelQ;
			`CUE_OFF_SYNCSEL: begin
				v[5:0]         = syncSelQ;
				v[`CUE_SYNC_EN] = syncEnQ;
			end
			`CUE_OFF_TYPE:    v[0] = protQ;
			`CUE_OFF_STATUS: begin
				v[1:0]                  = cap.seq;
				v[`CUE_STS_FLAGS +: 4]  = cap.flags;
			end
			`CUE_OFF_COUNT:   v = cap.counter;
			`CUE_OFF_HRFINE:  v[FINE_W-1:0] = fineQ;
			default: begin
				for (int k = 0; k < 4; k++) begin
					if (a == `CUE_OFF_CAP1 + 8'(4 * k)) begin
						v = cap.capVal[k];
					end
				end
			end
		endcase
		return v;
	endfunction : regView

	// decoded address answers at all
	function automatic logic isMapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `CUE_OFF_HRFINE);
	endfunction : isMapped

	// ============================================================
	// two-flop synchroniser on the crossbar and pin sources
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			srcMetaQ <= '0;
			srcSyncQ <= '0;
		end else begin
			srcMetaQ <= captureSources;
			srcSyncQ <= srcMetaQ;
		end
	end

	// ============================================================
	// source and sync selection feeding the core
	assign cap.capIn     = srcSyncQ[inSelQ];
	assign syncHit       = syncEnQ && (int'(syncSelQ) < NUM_SYNC)
		&& syncSources[syncSelQ];
	assign cap.syncPulse = syncHit;
	assign cap.run       = runQ;
	assign cap.falling   = fallQ;
	assign cap.filtReset = filtRstQ;
	assign cap.clrFlags  = clrQ;

	cue_capture_core u_core (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.cap     (cap)
	);

	// ============================================================
	// bus handshakes and register writes
	always_comb begin
		awRdyD   = awRdyQ;
		wRdyD    = wRdyQ;
		bValD    = bValQ;
		bRespD   = bRespQ;
		awAddrD  = awAddrQ;
		wDataD   = wDataQ;
		wStrbD   = wStrbQ;
		arRdyD   = arRdyQ;
		rValD    = rValQ;
		rDataD   = rDataQ;
		rRespD   = rRespQ;
		runD     = runQ;
		fallD    = fallQ;
		dmaEnD   = dmaEnQ;
		dmaSelD  = dmaSelQ;
		inSelD   = inSelQ;
		syncSelD = syncSelQ;
		syncEnD  = syncEnQ;
		protD    = protQ;
		filtRstD = 1'b0;
		clrD     = 4'h0;
		wVal     = 32'h0000_0000;
		if (s_axi_awvalid && awRdyQ) begin
			awAddrD = s_axi_awaddr;
			awRdyD  = 1'b0;
		end
		if (s_axi_wvalid && wRdyQ) begin
			wDataD = s_axi_wdata;
			wStrbD = s_axi_wstrb;
			wRdyD  = 1'b0;
		end
		doWrite = !awRdyQ && !wRdyQ && !bValQ;
		if (doWrite) begin
			bValD  = 1'b1;
			bRespD = `CUE_RESP_OKAY;
			wVal   = laneMerge(regView(awAddrQ), wDataQ, wStrbQ);
			if (!isMapped(awAddrQ)) begin
				bRespD = `CUE_RESP_DECERR;
			end else if (protQ && !protectedWriteGate
				&& awAddrQ != `CUE_OFF_STATUS) begin
				bRespD = `CUE_RESP_SLVERR;
			end else begin
				case (awAddrQ)
					`CUE_OFF_CTRL: begin
						runD     = wVal[`CUE_CTRL_RUN];
						filtRstD = wVal[`CUE_CTRL_FILTRST];
						dmaSelD  = cue_evt_t'(wVal[`CUE_CTRL_DMASEL +: 2]);
						dmaEnD   = wVal[`CUE_CTRL_DMAEN];
						fallD    = wVal[`CUE_CTRL_FALLING];
					end
					`CUE_OFF_INSEL:   inSelD = wVal[6:0];
					`CUE_OFF_SYNCSEL: begin
						syncSelD = wVal[5:0];
						syncEnD  = wVal[`CUE_SYNC_EN];
					end
					`CUE_OFF_TYPE:    protD = wVal[0];
					`CUE_OFF_STATUS:
						clrD = wDataQ[`CUE_STS_FLAGS +: 4] & {4{wStrbQ[0]}};
					default: ;
				endcase
			end
		end
		if (bValQ && s_axi_bready) begin
			bValD  = 1'b0;
			awRdyD = 1'b1;
			wRdyD  = 1'b1;
		end
		if (s_axi_arvalid && arRdyQ) begin
			arRdyD = 1'b0;
			rValD  = 1'b1;
			rDataD = regView(s_axi_araddr);
			rRespD = isMapped(s_axi_araddr) ? `CUE_RESP_OKAY
				: `CUE_RESP_DECERR;
		end
		if (rValQ && s_axi_rready) begin
			rValD  = 1'b0;
			arRdyD = 1'b1;
		end
	end

	// ============================================================
	// event outputs: dma request, sync output, high-res fine bits
	always_comb begin
		dmaReqD  = dmaEnQ && cap.evt[dmaSelQ];
		syncOutD = syncHit;
		fineD    = fineQ;
		if (HIGH_RES && (cap.evt != 4'h0)) begin
			fineD = hiResFine;
		end
	end

	// ============================================================
	// registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			awRdyQ   <= 1'b1;
			wRdyQ    <= 1'b1;
			bValQ    <= 1'b0;
			bRespQ   <= `CUE_RESP_OKAY;
			awAddrQ  <= 8'h00;
			wDataQ   <= 32'h0000_0000;
			wStrbQ   <= 4'h0;
			arRdyQ   <= 1'b1;
			rValQ    <= 1'b0;
			rDataQ   <= 32'h0000_0000;
			rRespQ   <= `CUE_RESP_OKAY;
			runQ     <= 1'b0;
			fallQ    <= 1'b0;
			dmaEnQ   <= 1'b0;
			dmaSelQ  <= CUE_EVT1;
			inSelQ   <= `CUE_RST_INSEL;
			syncSelQ <= `CUE_RST_SYNCSEL;
			syncEnQ  <= 1'b0;
			protQ    <= 1'b0;
			filtRstQ <= 1'b0;
			clrQ     <= 4'h0;
			fineQ    <= '0;
			dmaReqQ  <= 1'b0;
			syncOutQ <= 1'b0;
		end else begin
			awRdyQ   <= awRdyD;
			wRdyQ    <= wRdyD;
			bValQ    <= bValD;
			bRespQ   <= bRespD;
			awAddrQ  <= awAddrD;
			wDataQ   <= wDataD;
			wStrbQ   <= wStrbD;
			arRdyQ   <= arRdyD;
			rValQ    <= rValD;
			rDataQ   <= rDataD;
			rRespQ   <= rRespD;
			runQ     <= runD;
			fallQ    <= fallD;
			dmaEnQ   <= dmaEnD;
			dmaSelQ  <= dmaSelD;
			inSelQ   <= inSelD;
			syncSelQ <= syncSelD;
			syncEnQ  <= syncEnD;
			protQ    <= protD;
			filtRstQ <= filtRstD;
			clrQ     <= clrD;
			fineQ    <= fineD;
			dmaReqQ  <= dmaReqD;
			syncOutQ <= syncOutD;
		end
	end

	assign s_axi_awready = awRdyQ;
	assign s_axi_wready  = wRdyQ;
	assign s_axi_bvalid  = bValQ;
	assign s_axi_bresp   = bRespQ;
	assign s_axi_arready = arRdyQ;
	assign s_axi_rvalid  = rValQ;
	assign s_axi_rdata   = rDataQ;
	assign s_axi_rresp   = rRespQ;
	assign dmaRequest    = dmaReqQ;
	assign syncOutput    = syncOutQ;

endmodule : cue_capture_unit

/* rtl/cue_params.svh */
// ============================================================
// Purpose: offsets, field positions, reset values of the capture unit
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   definitions only
`ifndef CUE_PARAMS_SVH
`define CUE_PARAMS_SVH

// ============================================================
// register byte offsets
`define CUE_OFF_CTRL    8'h00
`define CUE_OFF_INSEL   8'h04
`define CUE_OFF_SYNCSEL 8'h08
`define CUE_OFF_TYPE    8'h0C
`define CUE_OFF_STATUS  8'h10
`define CUE_OFF_COUNT   8'h14
`define CUE_OFF_CAP1    8'h18
`define CUE_OFF_HRFINE  8'h28

// ============================================================
// control, sync select and status register fields
`define CUE_CTRL_RUN     0
`define CUE_CTRL_FILTRST 1
`define CUE_CTRL_DMASEL  2
`define CUE_CTRL_DMAEN   4
`define CUE_CTRL_FALLING 5
`define CUE_SYNC_EN      8
`define CUE_STS_FLAGS    2

// ============================================================
// reset values and bus answers
`define CUE_RST_INSEL    7'h7F
`define CUE_RST_SYNCSEL  6'h00
`define CUE_RESP_OKAY    2'h0
`define CUE_RESP_SLVERR  2'h2
`define CUE_RESP_DECERR  2'h3

`endif

/* rtl/cue_pkg.sv */
// ============================================================
// Purpose: shared types of the capture unit
// Assumes: nothing
// Notes:   constants live in cue_params.svh
package cue_pkg;

	typedef logic [31:0] cue_word_t;

	// capture event chosen for the dma request
	typedef enum logic [1:0] {
		CUE_EVT1 = 2'h0,
		CUE_EVT2 = 2'h1,
		CUE_EVT3 = 2'h2,
		CUE_EVT4 = 2'h3
	} cue_evt_t;

endpackage : cue_pkg

/* test/cue_capture_unit_asserts.sv */
// ============================================================
// Purpose: port-level checks of the capture unit
// Assumes: one clock domain, arst_n active low
// Notes:   bound into every cue_capture_unit instance
`timescale 1ns/1ps
module cue_capture_unit_asserts #(
	parameter int NUM_SYNC = 39
)(
	input wire logic                s_axi_awvalid,
	input wire logic                sys_clk,
	input wire logic                arst_n,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic [1:0]          s_axi_rresp,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	input wire logic [NUM_SYNC-1:0] syncSources,
	input wire logic                syncOutput,
	input wire logic                dmaRequest
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// ============================================================
	// event outputs
	property p_dma_pulse;
		dmaRequest |=> !dmaRequest;
	endproperty
	a_dma_pulse: assert property (p_dma_pulse)
		else $error("dma request wider than one cycle");
	property p_sync_src;
		$rose(syncOutput) |-> |$past(syncSources);
	endproperty
	a_sync_src: assert property (p_sync_src)
		else $error("sync output without a sync source hit");

	// ============================================================
	// register bus answers
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped early");
	property p_r_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_ans: assert property (p_r_ans)
		else $error("read answer late");
	property p_b_ans;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:3] s_axi_bvalid;
	endproperty
	a_b_ans: assert property (p_b_ans)
		else $error("write answer late");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block)
		else $error("read address taken during answer");
	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_block: assert property (p_aw_block)
		else $error("write taken during answer");
	property p_dec_zero;
		s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h0;
	endproperty
	a_dec_zero: assert property (p_dec_zero)
		else $error("refused read returned data");
endmodule : cue_capture_unit_asserts

bind cue_capture_unit cue_capture_unit_asserts #(.NUM_SYNC(NUM_SYNC))
	u_chk (.*);

/* test/cue_capture_unit_tb.sv */
// ============================================================
// Purpose: register-level test of the capture unit
// Assumes: UNIT_INDEX 1, so no high-res fine bits
// Notes:   sources come from cue_src_model
`timescale 1ns/1ps
`include "cue_params.svh"
module cue_capture_unit_tb
	import cue_pkg::*;
;
	logic       sys_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic       s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic       s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, hiResFine;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	cue_word_t  s_axi_wdata, s_axi_rdata;
	logic [127:0] captureSources;
	logic [38:0]  syncSources;
	logic       protectedWriteGate, syncOutput, dmaRequest, pinLvl, syncLvl;
	logic [6:0] pinIdx;
	logic [5:0] syncIdx;
	int         fails, num_checks, cyc, dmaCnt, syncCnt, d0, s, k;

	cue_capture_unit dut (.*);
	cue_src_model    u_src (.*);

	// ============================================================
	// clock, event counters and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (dmaRequest === 1'b1) dmaCnt++;
		if (syncOutput === 1'b1) syncCnt++;
		if (cyc == 30000) begin
			fails++;
			finish_test;
		end
	end

	// ============================================================
	// compare, verdict and bus tasks
	task check(input cue_word_t seen, input cue_word_t exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	// address and data offered together, each dropped when taken
	task wr(input logic [7:0] a, input cue_word_t d, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check(32'(s_axi_bresp), 32'(er));
	endtask : wr
	task rd(input logic [7:0] a, input cue_word_t ed, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, ed);
		check(32'(s_axi_rresp), 32'(er));
	endtask : rd
	task pulse;
		pinLvl <= 1'b1;
		repeat (8) @(posedge sys_clk);
		pinLvl <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask : pulse
	task spulse(input logic [5:0] i);
		syncIdx <= i;
		syncLvl <= 1'b1;
		@(posedge sys_clk);
		syncLvl <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask : spulse

	// ============================================================
	// main sequence
	initial begin
		{arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, pinLvl, syncLvl} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{protectedWriteGate, syncIdx} = 7'h00;
		s_axi_wstrb = 4'hF;
		hiResFine = 8'hA5;
		pinIdx = 7'h05;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(`CUE_OFF_INSEL, 32'h7F, `CUE_RESP_OKAY);
		rd(`CUE_OFF_TYPE, 32'h0, `CUE_RESP_OKAY);
		rd(8'h2C, 32'h0, `CUE_RESP_DECERR);
		wr(8'h2C, 32'hFFFFFFFF, `CUE_RESP_DECERR);
		wr(`CUE_OFF_INSEL, 32'h5, `CUE_RESP_OKAY);
		// every dma event select code, four events each
		for (s = 0; s < 4; s++) begin
			wr(`CUE_OFF_STATUS, 32'h3C, `CUE_RESP_OKAY);
			wr(`CUE_OFF_CTRL, 32'h13 | 32'(s << 2), `CUE_RESP_OKAY);
			d0 = dmaCnt;
			for (k = 0; k < 4; k++) begin
				pulse;
				check(32'(dmaCnt - d0), 32'(k >= s));
				rd(`CUE_OFF_STATUS, 32'((k + 1) % 4 | ((1 << (k + 1)) - 1) << 2),
					`CUE_RESP_OKAY);
			end
		end
		// filter reset in mid-sequence keeps flags, no false edge after
		pulse;
		pulse;
		wr(`CUE_OFF_CTRL, 32'h1F, `CUE_RESP_OKAY);
		rd(`CUE_OFF_STATUS, 32'h3C, `CUE_RESP_OKAY);
		pulse;
		rd(`CUE_OFF_STATUS, 32'h3D, `CUE_RESP_OKAY);
		rd(`CUE_OFF_HRFINE, 32'h0, `CUE_RESP_OKAY);
		// falling mode: filter reset with pin low, then a rising and a falling edge
		wr(`CUE_OFF_CTRL, 32'h23, `CUE_RESP_OKAY);
		rd(`CUE_OFF_STATUS, 32'h3C, `CUE_RESP_OKAY);
		pinLvl <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rd(`CUE_OFF_STATUS, 32'h3C, `CUE_RESP_OKAY);
		pinLvl <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rd(`CUE_OFF_STATUS, 32'h3D, `CUE_RESP_OKAY);
		rd(`CUE_OFF_CTRL, 32'h21, `CUE_RESP_OKAY);
		// a pwm source and a capture source, each beside a decoy
		for (s = 0; s < 2; s++) begin
			k = s ? 37 : 3;
			wr(`CUE_OFF_SYNCSEL, 32'h100 | 32'(k), `CUE_RESP_OKAY);
			d0 = syncCnt;
			spulse(6'(k ^ 1));
			spulse(6'(k));
			check(32'(syncCnt - d0), 32'h1);
		end
		// stopped counter is still zeroed by the selected sync source
		wr(`CUE_OFF_CTRL, 32'h0, `CUE_RESP_OKAY);
		spulse(6'(k));
		rd(`CUE_OFF_COUNT, 32'h0, `CUE_RESP_OKAY);
		wr(`CUE_OFF_TYPE, 32'h1, `CUE_RESP_OKAY);
		wr(`CUE_OFF_INSEL, 32'h9, `CUE_RESP_SLVERR);
		rd(`CUE_OFF_INSEL, 32'h5, `CUE_RESP_OKAY);
		// flag clear stays open while protection is on
		wr(`CUE_OFF_STATUS, 32'h3C, `CUE_RESP_OKAY);
		rd(`CUE_OFF_STATUS, 32'h1, `CUE_RESP_OKAY);
		protectedWriteGate <= 1'b1;
		wr(`CUE_OFF_INSEL, 32'h9, `CUE_RESP_OKAY);
		rd(`CUE_OFF_INSEL, 32'h9, `CUE_RESP_OKAY);
		finish_test;
	end
endmodule : cue_capture_unit_tb

/* test/cue_src_model.sv */
// ============================================================
// Purpose: capture pins and peer sync sources around the unit
// Assumes: pins change just after a clock edge
// Notes:   unselected sources rest low
`timescale 1ns/1ps
module cue_src_model (
	input  wire logic [6:0] pinIdx,
	input  wire logic       sys_clk,
	input  wire logic       pinLvl,
	input  wire logic [5:0] syncIdx,
	input  wire logic       syncLvl,
	output logic [127:0]    captureSources,
	output logic [38:0]     syncSources
);
	// one active source at a time, so a wrong select sees nothing
	always_ff @(posedge sys_clk) begin
		captureSources <= 128'(pinLvl) << pinIdx;
		syncSources    <= 39'(syncLvl) << syncIdx;
	end
endmodule : cue_src_model
